/* File: hw/flash_boot_entry_and_ram_emulation.sv */
`timescale 1ns/10ps
// Operation
// - Erase block parameter 0 to 11 selects erase blocks zero to eleven.
// - Any erase block parameter above 11 reports an error.
// - Enabled overlay maps RAM window FFA000-FFAFFF onto chosen flash area.
// - Overlay control bits 7 to 4 read zero; writes ignored.
// - Overlay control bit 3 enables RAM emulation; resets to zero.
// - While emulation is enabled all program and erase is blocked.
// - Area code 000..111 selects 4-Kbyte blocks zero through seven.
// - Area code acts only while enable bit is one.
// - On-board programming entered only at reset with emulator pin low.
// - Emulator pin low: 001 user boot, 010 boot, 11x user program.
// - Boot mode ignores interrupts; system raises none.
// - Boot serial uses 8 data bits, one stop, no parity.
// - Host sends 00 bytes; device measures low time and sets baud.
// - After baud adjustment the device sends one 00 byte.
// - After host sends 55 the device erases whole user and user boot flash.
module flash_boot_entry_and_ram_emulation (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        emulator_enable_pin,
  input  wire logic        mode_pin_2,
  input  wire logic        mode_pin_1,
  input  wire logic        mode_pin_0,
  input  wire logic        serial_rx,
  output logic             serial_tx,
  input  wire logic [23:0] cpu_addr,
  output logic [23:0]      mapped_addr,
  output logic             overlay_hit,
  output logic             pe_blocked,
  output logic             irq_block,
  output logic             erase_start,
  output logic             erase_all_start,
  output logic [3:0]       erase_block,
  input  wire logic        flash_done,
  output flash_boot_pkg::mode_t op_mode,
  output logic             mode_valid
);
  import flash_boot_pkg::*;

  // ==========================================
  // State
  typedef struct packed {
    logic [3:0]        pin_meta;
    logic [3:0]        pin_sync;
    logic              rx_meta;
    logic              rx_sync;
    logic [1:0]        settle;
    logic              mode_valid;
    mode_t             mode;
    logic              irq_block;
    boot_t             boot;
    logic [baud_w-1:0] bit_cycles;
    logic              meas_start;
    logic              rx_enable;
    logic              tx_start;
    logic              ovl_en;
    logic [2:0]        ovl_area;
    logic [23:0]       mapped_addr;
    logic              overlay_hit;
    logic              erase_start;
    logic              erase_all_start;
    logic [3:0]        erase_block;
    logic              erase_busy;
    logic              erase_error;
    logic              waitrequest;
    logic [31:0]       readdata;
  } top_state_t;

  top_state_t cur;
  top_state_t next_cur;
  serial_link_if link ();

  // ==========================================
  // Helpers
  function automatic mode_t decode_mode(input logic [3:0] pins);
    mode_t m;
    m = mode_user;
    if (!pins[3]) begin
      case (pins[2:0])
        3'h1: m = mode_user_boot;
        3'h2: m = mode_boot;
        3'h6, 3'h7: m = mode_user_program;
        default: m = mode_user;
      endcase
    end
    return m;
  endfunction

  function automatic logic [baud_w-1:0] baud_from_low(
    input logic [meas_w-1:0] low);
    logic [meas_w:0] t;
    t = {1'b0, low} + (meas_w + 1)'(low_bits_of_sync / 2);
    return baud_w'(t / (meas_w + 1)'(low_bits_of_sync));
  endfunction

  function automatic logic overlay_match(input logic en,
    input logic [2:0] area, input logic [23:0] addr);
    return en && addr[23:15] == flash_low_zero &&
           addr[14:12] == area;
  endfunction

  logic [31:0] status_word;
  logic        erase_allowed;

  always_comb begin
    status_word = '0;
    status_word[st_mode_lsb +: 2]   = cur.mode;
    status_word[st_mode_valid]      = cur.mode_valid;
    status_word[st_boot_lsb +: 3]   = cur.boot;
    status_word[st_erase_busy]      = cur.erase_busy;
    status_word[st_erase_error]     = cur.erase_error;
    status_word[st_blocked]         = cur.ovl_en;
    status_word[st_baud_lsb +: baud_w] = cur.bit_cycles;
  end

  assign erase_allowed = cur.mode == mode_user_program ||
                         cur.boot == bs_ready;

  // ==========================================
  // Next state
  always_comb begin
    next_cur = cur;
    next_cur.pin_meta = {emulator_enable_pin, mode_pin_2, mode_pin_1,
                         mode_pin_0};
    next_cur.pin_sync = cur.pin_meta;
    next_cur.rx_meta = serial_rx;
    next_cur.rx_sync = cur.rx_meta;
    next_cur.meas_start = 1'b0;
    next_cur.tx_start = 1'b0;
    next_cur.erase_start = 1'b0;
    next_cur.erase_all_start = 1'b0;

    // Strap capture once the pin synchroniser has filled
    if (!cur.mode_valid) begin
      if (cur.settle == strap_settle) begin
        next_cur.mode_valid = 1'b1;
        next_cur.mode = decode_mode(cur.pin_sync);
        next_cur.irq_block = decode_mode(cur.pin_sync) == mode_boot;
        if (decode_mode(cur.pin_sync) == mode_boot) begin
          next_cur.boot = bs_measure;
          next_cur.meas_start = 1'b1;
        end
      end else begin
        next_cur.settle = cur.settle + 2'h1;
      end
    end

    // Boot entry handshake
    case (cur.boot)
      bs_off: begin
      end
      bs_measure: if (link.meas_done) begin
        next_cur.bit_cycles = baud_from_low(link.meas_low);
        if (baud_from_low(link.meas_low) == '0) begin
          next_cur.boot = bs_fail;
        end else begin
          next_cur.tx_start = 1'b1;
          next_cur.boot = bs_send_end;
        end
      end
      bs_send_end: if (link.tx_done) begin
        next_cur.rx_enable = 1'b1;
        next_cur.boot = bs_wait_ack;
      end
      // Trailing sync bytes may still arrive before the answer
      bs_wait_ack: begin
        if (link.rx_err) begin
          next_cur.rx_enable = 1'b0;
          next_cur.boot = bs_fail;
        end else if (link.rx_valid) begin
          if (link.rx_data == host_ack_byte) begin
            next_cur.rx_enable = 1'b0;
            next_cur.erase_all_start = 1'b1;
            next_cur.erase_busy = 1'b1;
            next_cur.boot = bs_auto_erase;
          end else if (link.rx_data != host_sync_byte) begin
            next_cur.rx_enable = 1'b0;
            next_cur.boot = bs_fail;
          end
        end
      end
      bs_auto_erase: if (flash_done) begin
        next_cur.erase_busy = 1'b0;
        next_cur.boot = bs_ready;
      end
      bs_ready, bs_fail: begin
      end
      default: next_cur.boot = bs_off;
    endcase

    if (cur.erase_busy && flash_done && cur.boot != bs_auto_erase)
      next_cur.erase_busy = 1'b0;

    // Overlay address redirection, one cycle of latency
    next_cur.overlay_hit = overlay_match(cur.ovl_en, cur.ovl_area,
                                         cpu_addr);
    next_cur.mapped_addr = cpu_addr;
    if (overlay_match(cur.ovl_en, cur.ovl_area, cpu_addr))
      next_cur.mapped_addr = {ram_window_page, cpu_addr[11:0]};

    // Register slave: answer one cycle after the request is taken
    if (!cur.waitrequest) begin
      next_cur.waitrequest = 1'b1;
      if (avs_write) begin
        case (avs_address)
          off_overlay_ctrl: begin
            // Ignored while boot programs own the flash
            if ((avs_byteenable & be_low_lane) != 4'h0 &&
                (cur.mode == mode_user ||
                 cur.mode == mode_user_program)) begin
              next_cur.ovl_en = avs_writedata[overlay_en_bit];
              next_cur.ovl_area = avs_writedata[2:0];
            end
          end
          off_erase_cmd: if (!cur.erase_busy) begin
            if (avs_writedata > erase_block_max) begin
              next_cur.erase_error = 1'b1;
            end else if (cur.ovl_en || !erase_allowed) begin
              next_cur.erase_error = 1'b1;
            end else begin
              next_cur.erase_error = 1'b0;
              next_cur.erase_block = avs_writedata[3:0];
              next_cur.erase_start = 1'b1;
              next_cur.erase_busy = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (avs_read || avs_write) begin
      next_cur.waitrequest = 1'b0;
      case (avs_address)
        off_overlay_ctrl:
          next_cur.readdata = {28'h0, cur.ovl_en, cur.ovl_area};
        off_status: next_cur.readdata = status_word;
        off_erase_cmd: next_cur.readdata = {28'h0, cur.erase_block};
        default: next_cur.readdata = '0;
      endcase
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= '0;
      cur.ovl_en <= overlay_reset[overlay_en_bit];
      cur.pin_meta <= 4'hf;
      cur.pin_sync <= 4'hf;
      cur.rx_meta <= 1'b1;
      cur.rx_sync <= 1'b1;
      cur.waitrequest <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================
  // Serial engines
  assign link.rx_level   = cur.rx_sync;
  assign link.meas_start = cur.meas_start;
  assign link.bit_cycles = cur.bit_cycles;
  assign link.rx_enable  = cur.rx_enable;
  assign link.tx_start   = cur.tx_start;
  assign link.tx_data    = adjust_end_byte;

  serial_rx_unit u_rx (
    .clk   (clk),
    .reset (reset),
    .link  (link.rx)
  );

  serial_tx_unit u_tx (
    .clk       (clk),
    .reset     (reset),
    .link      (link.tx),
    .serial_tx (serial_tx)
  );

  // ==========================================
  // Outputs
  assign avs_readdata    = cur.readdata;
  assign avs_waitrequest = cur.waitrequest;
  assign mapped_addr     = cur.mapped_addr;
  assign overlay_hit     = cur.overlay_hit;
  assign pe_blocked      = cur.ovl_en;
  assign irq_block       = cur.irq_block;
  assign erase_start     = cur.erase_start;
  assign erase_all_start = cur.erase_all_start;
  assign erase_block     = cur.erase_block;
  assign op_mode         = cur.mode;
  assign mode_valid      = cur.mode_valid;
endmodule

/* File: hw/flash_boot_pkg.sv */
package flash_boot_pkg;
  // ==========================================
  // Register map (byte offsets)
  localparam logic [3:0]  off_overlay_ctrl = 4'h0;
  localparam logic [3:0]  off_status       = 4'h4;
  localparam logic [3:0]  off_erase_cmd    = 4'h8;
  localparam logic [7:0]  overlay_reset    = 8'h00;
  localparam int          overlay_en_bit   = 3;
  localparam logic [31:0] erase_block_max  = 32'h0000000b;
  localparam logic [3:0]  be_low_lane      = 4'h1;
  // Status field positions
  localparam int st_mode_lsb    = 0;
  localparam int st_mode_valid  = 2;
  localparam int st_boot_lsb    = 3;
  localparam int st_erase_busy  = 6;
  localparam int st_erase_error = 7;
  localparam int st_blocked     = 8;
  localparam int st_baud_lsb    = 12;
  // ==========================================
  // Overlay geometry
  localparam logic [11:0] ram_window_page = 12'hffa;
  localparam logic [8:0]  flash_low_zero  = 9'h000;
  // ==========================================
  // Serial handshake
  localparam logic [7:0] adjust_end_byte = 8'h00;
  localparam logic [7:0] host_ack_byte   = 8'h55;
  localparam logic [7:0] host_sync_byte  = 8'h00;
  localparam int         low_bits_of_sync = 9;
  localparam int         frame_bits       = 10;
  localparam int         meas_w           = 22;
  localparam int         baud_w           = 20;
  localparam logic [1:0] strap_settle     = 2'h3;
  // ==========================================
  // Modes and states
  typedef enum logic [1:0] {
    mode_user, mode_user_boot, mode_boot, mode_user_program
  } mode_t;
  typedef enum logic [2:0] {
    bs_off, bs_measure, bs_send_end, bs_wait_ack, bs_auto_erase,
    bs_ready, bs_fail
  } boot_t;
endpackage

/* File: hw/serial_link_if.sv */
`timescale 1ns/10ps
interface serial_link_if;
  import flash_boot_pkg::*;
  logic              rx_level;
  logic              meas_start;
  logic              meas_done;
  logic [meas_w-1:0] meas_low;
  logic [baud_w-1:0] bit_cycles;
  logic              rx_enable;
  logic              rx_valid;
  logic              rx_err;
  logic [7:0]        rx_data;
  logic              tx_start;
  logic [7:0]        tx_data;
  logic              tx_done;
  modport ctrl (input meas_done, meas_low, rx_valid, rx_err, rx_data,
                tx_done, output rx_level, meas_start, bit_cycles,
                rx_enable, tx_start, tx_data);
  modport rx (input rx_level, meas_start, bit_cycles, rx_enable,
              output meas_done, meas_low, rx_valid, rx_err, rx_data);
  modport tx (input bit_cycles, tx_start, tx_data, output tx_done);
endinterface

/* File: hw/serial_rx_unit.sv */
`timescale 1ns/10ps
module serial_rx_unit (
  input wire logic    clk,
  input wire logic    reset,
  serial_link_if.rx   link
);
  import flash_boot_pkg::*;
  typedef enum logic [2:0] {
    r_off, r_meas_high, r_meas_low, r_arm, r_idle, r_start, r_bits, r_stop
  } rx_st_t;
  typedef struct packed {
    rx_st_t            st;
    logic [meas_w-1:0] cnt;
    logic [2:0]        nbit;
    logic [7:0]        shift;
    logic              meas_done;
    logic [meas_w-1:0] meas_low;
    logic              valid;
    logic              err;
  } rx_state_t;
  rx_state_t cur;
  rx_state_t next_cur;
  logic [meas_w-1:0] bit_end;
  logic [meas_w-1:0] half_end;

  assign bit_end  = meas_w'(link.bit_cycles) - meas_w'(1);
  assign half_end = meas_w'(link.bit_cycles >> 1);
  assign link.meas_done = cur.meas_done;
  assign link.meas_low  = cur.meas_low;
  assign link.rx_valid  = cur.valid;
  assign link.rx_err    = cur.err;
  assign link.rx_data   = cur.shift;

  always_comb begin
    next_cur = cur;
    next_cur.meas_done = 1'b0;
    next_cur.valid = 1'b0;
    next_cur.err = 1'b0;
    next_cur.cnt = cur.cnt + meas_w'(1);
    case (cur.st)
      r_off: begin
        if (link.meas_start) next_cur.st = r_meas_high;
        else if (link.rx_enable) next_cur.st = r_arm;
      end
      // Low time of one sync byte: start bit plus eight zero bits
      r_meas_high: begin
        next_cur.cnt = '0;
        if (!link.rx_level) next_cur.st = r_meas_low;
      end
      r_meas_low: begin
        if (&cur.cnt) next_cur.cnt = cur.cnt;
        if (link.rx_level) begin
          next_cur.meas_done = 1'b1;
          next_cur.meas_low = cur.cnt;
          next_cur.st = r_off;
        end
      end
      // Wait for idle line so a partial byte is never framed
      r_arm: if (link.rx_level) next_cur.st = r_idle;
      r_idle: begin
        next_cur.cnt = '0;
        if (!link.rx_level) next_cur.st = r_start;
      end
      r_start: if (cur.cnt == half_end) begin
        next_cur.cnt = '0;
        next_cur.nbit = '0;
        next_cur.st = link.rx_level ? r_idle : r_bits;
      end
      r_bits: if (cur.cnt == bit_end) begin
        next_cur.cnt = '0;
        next_cur.shift = {link.rx_level, cur.shift[7:1]};
        next_cur.nbit = cur.nbit + 3'h1;
        if (&cur.nbit) next_cur.st = r_stop;
      end
      r_stop: if (cur.cnt == bit_end) begin
        next_cur.valid = link.rx_level;
        next_cur.err = !link.rx_level;
        next_cur.st = r_idle;
      end
      default: next_cur.st = r_off;
    endcase
    if (!link.rx_enable && cur.st inside {r_arm, r_idle, r_start, r_bits,
                                          r_stop})
      next_cur.st = r_off;
  end

  always_ff @(posedge clk) begin
    if (reset) cur <= '0;
    else cur <= next_cur;
  end
endmodule

/* File: hw/serial_tx_unit.sv */
`timescale 1ns/10ps
module serial_tx_unit (
  input wire logic    clk,
  input wire logic    reset,
  serial_link_if.tx   link,
  output logic        serial_tx
);
  import flash_boot_pkg::*;
  typedef struct packed {
    logic                  busy;
    logic [baud_w-1:0]     cnt;
    logic [3:0]            nbit;
    logic [frame_bits-1:0] shift;
    logic                  line;
    logic                  done;
  } tx_state_t;
  tx_state_t cur;
  tx_state_t next_cur;

  assign serial_tx = cur.line;
  assign link.tx_done = cur.done;

  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    if (!cur.busy) begin
      next_cur.line = 1'b1;
      if (link.tx_start) begin
        // Stop, eight data bits, start; no parity
        next_cur.shift = {1'b1, link.tx_data, 1'b0};
        next_cur.busy = 1'b1;
        next_cur.cnt = '0;
        next_cur.nbit = '0;
        next_cur.line = 1'b0;
      end
    end else if (cur.cnt == link.bit_cycles - baud_w'(1)) begin
      next_cur.cnt = '0;
      next_cur.nbit = cur.nbit + 4'h1;
      next_cur.shift = {1'b1, cur.shift[frame_bits-1:1]};
      next_cur.line = cur.shift[1];
      if (cur.nbit == 4'(frame_bits - 1)) begin
        next_cur.busy = 1'b0;
        next_cur.done = 1'b1;
        next_cur.line = 1'b1;
      end
    end else begin
      next_cur.cnt = cur.cnt + baud_w'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) cur <= '{busy: 1'b0, cnt: '0, nbit: '0, shift: '1,
                        line: 1'b1, done: 1'b0};
    else cur <= next_cur;
  end
endmodule

/* File: testbench/flash_boot_sva.sv */
`timescale 1ns/10ps
// ==========================================
// Port checks
module flash_boot_sva (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic [3:0]            avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic [23:0]           cpu_addr,
  input wire logic [23:0]           mapped_addr,
  input wire logic                  overlay_hit,
  input wire logic                  pe_blocked,
  input wire logic                  irq_block,
  input wire logic                  erase_start,
  input wire logic                  erase_all_start,
  input wire logic                  serial_tx,
  input wire flash_boot_pkg::mode_t op_mode,
  input wire logic                  mode_valid
);
  import flash_boot_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence taken_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence answer_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_answer_a: assert property (taken_s |=> answer_s)
    else $error("bus answer missing");
  stray_ack_a: assert property (!avs_waitrequest |->
    $past(avs_read || avs_write))
    else $error("ack without request");
  ctrl_upper_a: assert property (!avs_waitrequest && avs_read &&
    avs_address == off_overlay_ctrl |-> avs_readdata[31:4] == 28'h0)
    else $error("control upper bits set");
  map_window_a: assert property (overlay_hit |->
    mapped_addr == {ram_window_page, $past(cpu_addr[11:0])})
    else $error("overlay address wrong");
  hit_block_a: assert property (overlay_hit |->
    $past(pe_blocked) && $past(cpu_addr[23:15]) == flash_low_zero)
    else $error("hit outside flash area");
  pass_through_a: assert property (!$past(reset) && !overlay_hit |->
    mapped_addr == $past(cpu_addr))
    else $error("address altered without hit");
  erase_free_a: assert property (erase_start |->
    !pe_blocked && !$past(pe_blocked))
    else $error("erase while blocked");
  erase_pulse_a: assert property (erase_start |=> !erase_start)
    else $error("erase pulse too long");
  wipe_boot_a: assert property (erase_all_start |->
    op_mode == mode_boot ##1 !erase_all_start)
    else $error("erase all outside boot");
  irq_mode_a: assert property (irq_block |->
    mode_valid && op_mode == mode_boot)
    else $error("interrupt block outside boot");
  quiet_tx_a: assert property (mode_valid && op_mode != mode_boot
    |-> serial_tx)
    else $error("serial traffic outside boot");
  mode_hold_a: assert property (mode_valid |=>
    mode_valid && $stable(op_mode))
    else $error("mode changed without reset");
endmodule

bind flash_boot_entry_and_ram_emulation flash_boot_sva u_sva (
  .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .cpu_addr, .mapped_addr, .overlay_hit, .pe_blocked,
  .irq_block, .erase_start, .erase_all_start, .serial_tx, .op_mode,
  .mode_valid
);

/* File: testbench/host_uart_model.sv */
`timescale 1ns/10ps
// ==========================================
// Host tool on the boot serial link
module host_uart_model #(
  parameter int bit_cyc = 50
) (
  input  wire logic  clk,
  input  wire logic  go,
  input  wire logic  serial_tx,
  output logic       serial_rx,
  output logic [7:0] heard,
  output logic       done
);
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx <= f[i];
      repeat (bit_cyc) @(posedge clk);
    end
  endtask

  initial begin
    serial_rx = 1'b1;
    heard = 8'hff;
    done = 1'b0;
    while (go !== 1'b1) @(posedge clk);
    repeat (bit_cyc) @(posedge clk);
    // Sync byte; stop bit left open to catch a prompt reply
    serial_rx <= 1'b0;
    repeat (9 * bit_cyc) @(posedge clk);
    serial_rx <= 1'b1;
    for (int k = 0; k < 2000 && serial_tx !== 1'b0; k++) @(posedge clk);
    repeat (bit_cyc + bit_cyc / 2) @(posedge clk);
    for (int j = 0; j < 8; j++) begin
      heard[j] = serial_tx;
      repeat (bit_cyc) @(posedge clk);
    end
    repeat (bit_cyc) @(posedge clk);
    if (heard == 8'h00) begin
      send(8'h55);
      // Erase phase end marker, must be ignored here
      send(8'hff);
    end
    done <= 1'b1;
  end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import flash_boot_pkg::*;
  typedef struct packed {
    logic [3:0]  wa;
    logic [31:0] wd;
    logic [3:0]  be;
    logic [3:0]  ra;
    logic [31:0] mk;
    logic [31:0] ex;
  } row_t;
  localparam logic [3:0] ctl = off_overlay_ctrl;
  localparam logic [3:0] sts = off_status;
  localparam logic [3:0] ers = off_erase_cmd;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [3:0]  straps = 4'h6;
  logic [23:0] cpu_addr = 24'h0;
  logic        flash_done = 1'b0;
  logic        go = 1'b0;
  logic [31:0] avs_readdata, q;
  logic [23:0] mapped_addr;
  logic        avs_waitrequest, overlay_hit, pe_blocked, irq_block;
  logic        erase_start, erase_all_start, serial_rx, serial_tx;
  logic        mode_valid, host_done;
  logic [3:0]  erase_block;
  logic [7:0]  heard;
  mode_t       op_mode;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          starts = 0;
  int          alls = 0;
  row_t rows [10] = '{
    '{ctl, 32'hff, 4'hf, ctl, 32'hffffffff, 32'h0f},
    '{ctl, 32'h00, 4'he, ctl, 32'hffffffff, 32'h0f},
    '{ctl, 32'h08, 4'h1, sts, 32'h100, 32'h100},
    '{ers, 32'h00, 4'hf, sts, 32'h80, 32'h80},
    '{ctl, 32'h00, 4'h1, ctl, 32'hffffffff, 32'h00},
    '{ers, 32'h00, 4'hf, sts, 32'h80, 32'h00},
    '{ers, 32'h0b, 4'hf, ers, 32'h0f, 32'h0b},
    '{ers, 32'h0c, 4'hf, sts, 32'h80, 32'h80},
    '{ers, 32'h100, 4'hf, sts, 32'h80, 32'h80},
    '{4'hc, 32'h01, 4'hf, 4'hc, 32'hffffffff, 32'h00}
  };
  logic [3:0] strap_tbl [6] = '{4'h1, 4'h2, 4'h6, 4'h7, 4'ha, 4'h0};
  mode_t mode_tbl [6] = '{mode_user_boot, mode_boot, mode_user_program,
                          mode_user_program, mode_user, mode_user};

  flash_boot_entry_and_ram_emulation u_dut (
    .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .emulator_enable_pin(straps[3]), .mode_pin_2(straps[2]),
    .mode_pin_1(straps[1]), .mode_pin_0(straps[0]), .serial_rx,
    .serial_tx, .cpu_addr, .mapped_addr, .overlay_hit, .pe_blocked,
    .irq_block, .erase_start, .erase_all_start, .erase_block, .flash_done,
    .op_mode, .mode_valid
  );
  host_uart_model #(.bit_cyc(50)) u_host (
    .clk, .go, .serial_tx, .serial_rx, .heard, .done(host_done)
  );

  // ==========================================
  // Clock, flash controller stand-in, timeout
  always #2 clk = ~clk;
  always @(posedge clk) begin
    flash_done <= (erase_start === 1'b1) || (erase_all_start === 1'b1);
    if (erase_start === 1'b1)
      starts++;
    if (erase_all_start === 1'b1)
      alls++;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // ==========================================
  // Tasks
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic restart(input logic [3:0] s);
    reset <= 1'b1;
    straps <= s;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    restart(4'h6);
    xfer(1'b0, ctl, 32'h0, 4'h0);
    check("control reset", q, {24'h0, overlay_reset});
    xfer(1'b0, sts, 32'h0, 4'h0);
    check("status mode", q & 32'h7, 32'h7);
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].wa, rows[i].wd, rows[i].be);
      xfer(1'b0, rows[i].ra, 32'h0, 4'h0);
      check("register row", q & rows[i].mk, rows[i].ex);
    end
    check("erase starts", 32'(starts), 32'h2);
    check("erase block", 32'(erase_block), 32'hb);
    for (int a = 0; a < 8; a++) begin
      xfer(1'b1, ctl, 32'(8 + a), be_low_lane);
      cpu_addr <= {9'h0, 3'(a), 12'h123};
      repeat (3) @(posedge clk);
      check("hit", 32'(overlay_hit), 32'h1);
      check("mapped", 32'(mapped_addr), 32'hffa123);
      check("blocked", 32'(pe_blocked), 32'h1);
      cpu_addr <= {9'h0, 3'(a + 1), 12'h123};
      repeat (3) @(posedge clk);
      check("other block", 32'(overlay_hit), 32'h0);
      xfer(1'b1, ctl, 32'(a), be_low_lane);
      cpu_addr <= {9'h0, 3'(a), 12'h123};
      repeat (3) @(posedge clk);
      check("disabled", 32'(overlay_hit), 32'h0);
      check("pass", 32'(mapped_addr), {17'h0, 3'(a), 12'h123});
    end
    cpu_addr <= 24'h0;
    for (int i = 0; i < 6; i++) begin
      restart(strap_tbl[i]);
      check("mode", 32'(op_mode), 32'(mode_tbl[i]));
      check("mode valid", 32'(mode_valid), 32'h1);
      check("irq level", 32'(irq_block), 32'(mode_tbl[i] == mode_boot));
    end
    restart(4'h2);
    check("interrupt block", 32'(irq_block), 32'h1);
    xfer(1'b1, ctl, 32'h8, be_low_lane);
    xfer(1'b0, ctl, 32'h0, 4'h0);
    check("boot control", q, 32'h0);
    go <= 1'b1;
    while (host_done !== 1'b1) @(posedge clk);
    check("end byte", 32'(heard), 32'h0);
    while (alls == 0) @(posedge clk);
    repeat (4) @(posedge clk);
    xfer(1'b0, sts, 32'h0, 4'h0);
    check("boot state", 32'(q[5:3]), 32'h5);
    check("bit cycles", 32'(q[31:12]), 32'd50);
    check("erase all", 32'(alls), 32'h1);
    give_verdict();
  end
endmodule
